// ### rtl/direct_window.sv
/*
 * direct processor-to-memory path decoder: two window registers written
 * from the PCI route or the processor route, request decode and forward.
 * assumes: requests and register strobes come from logic on CLK_I; the
 * addressing mode arrives on a static board pin.
 */
`timescale 1ns/10ps
module direct_window (
    // clock and reset
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    // board strap: 1 = 36-bit extended addressing in effect
    input wire logic ADDR36_I,
    // register access through the PCI register window
    input wire logic PCI_REG_WR_I,
    input wire logic PCI_REG_RD_I,
    input wire logic [window_pkg::REG_AW-1:0] PCI_REG_ADDR_I,
    input wire logic [window_pkg::REG_DW-1:0] PCI_REG_WDATA_I,
    output logic [window_pkg::REG_DW-1:0] PCI_REG_RDATA_O,
    // register access through the processor register window
    input wire logic CPU_REG_WR_I,
    input wire logic CPU_REG_RD_I,
    input wire logic [window_pkg::REG_AW-1:0] CPU_REG_ADDR_I,
    input wire logic [window_pkg::REG_DW-1:0] CPU_REG_WDATA_I,
    output logic [window_pkg::REG_DW-1:0] CPU_REG_RDATA_O,
    // processor bus request
    input wire logic REQ_VALID_I,
    input wire logic REQ_WRITE_I,
    input wire logic [window_pkg::ADDR_W-1:0] REQ_ADDR_I,
    // forward to memory controller
    output logic CLAIM_O,
    output logic MEM_VALID_O,
    output logic MEM_WRITE_O,
    output logic [window_pkg::ADDR_W-1:0] MEM_ADDR_O,
    output logic WIN_SEL_O,
    output logic WR_ERR_O
);
    import window_pkg::*;

    // decodes a register offset to a window slot, -1 when unmapped
    function automatic int reg_slot(input logic [REG_AW-1:0] a);
        if (a == WIN_ONE_OFS) begin
            return 0;
        end else if (a == WIN_TWO_OFS) begin
            return 1;
        end
        return -1;
    endfunction

    // ----------------------------------------------------------------
    // mode pin synchroniser
    // ----------------------------------------------------------------
    logic mode_meta_q, mode_meta_d, mode_q, mode_d;
    always_comb begin
        mode_meta_d = ADDR36_I;
        mode_d = mode_meta_q;
    end
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            mode_meta_q <= 1'b0;
            mode_q <= 1'b0;
        end else begin
            mode_meta_q <= mode_meta_d;
            mode_q <= mode_d;
        end
    end

    // ----------------------------------------------------------------
    // window registers, both routes
    // ----------------------------------------------------------------
    logic [REG_DW-1:0] cfg_q [WIN_N];
    logic [REG_DW-1:0] cfg_d [WIN_N];
    logic [REG_DW-1:0] pci_rdata_q, pci_rdata_d, cpu_rdata_q, cpu_rdata_d;
    int pci_slot, cpu_slot;

    // the PCI route wins when both write one register in one cycle
    always_comb begin
        pci_slot = reg_slot(PCI_REG_ADDR_I);
        cpu_slot = reg_slot(CPU_REG_ADDR_I);
        for (int i = 0; i < WIN_N; i++) begin
            cfg_d[i] = cfg_q[i];
            if (CPU_REG_WR_I && cpu_slot == i) begin
                cfg_d[i] = CPU_REG_WDATA_I & CFG_USED_MASK;
            end
            if (PCI_REG_WR_I && pci_slot == i) begin
                cfg_d[i] = PCI_REG_WDATA_I & CFG_USED_MASK;
            end
        end
        // unmapped offsets read as zero
        pci_rdata_d = pci_rdata_q;
        if (PCI_REG_RD_I) begin
            pci_rdata_d = (pci_slot >= 0) ? cfg_q[pci_slot[0]] : CFG_RESET;
        end
        cpu_rdata_d = cpu_rdata_q;
        if (CPU_REG_RD_I) begin
            cpu_rdata_d = (cpu_slot >= 0) ? cfg_q[cpu_slot[0]] : CFG_RESET;
        end
    end
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            for (int i = 0; i < WIN_N; i++) begin
                cfg_q[i] <= CFG_RESET;
            end
            pci_rdata_q <= CFG_RESET;
            cpu_rdata_q <= CFG_RESET;
        end else begin
            cfg_q <= cfg_d;
            pci_rdata_q <= pci_rdata_d;
            cpu_rdata_q <= cpu_rdata_d;
        end
    end
    assign PCI_REG_RDATA_O = pci_rdata_q;
    assign CPU_REG_RDATA_O = cpu_rdata_q;

    // ----------------------------------------------------------------
    // per-window decode
    // ----------------------------------------------------------------
    logic [WIN_N-1:0] hit, lock;
    logic [ADDR_W-1:0] xaddr [WIN_N];
    for (genvar g = 0; g < WIN_N; g++) begin : g_win
        window_match u_match (
            .cfg_i(cfg_q[g]),
            .wide_i(mode_q),
            .addr_i(REQ_ADDR_I),
            .hit_o(hit[g]),
            .lock_o(lock[g]),
            .addr_o(xaddr[g])
        );
    end

    // ----------------------------------------------------------------
    // claim and forward, one cycle after the request
    // ----------------------------------------------------------------
    logic claim_q, claim_d, mvalid_q, mvalid_d, mwrite_q, mwrite_d;
    logic sel_q, sel_d, err_q, err_d;
    logic [ADDR_W-1:0] maddr_q, maddr_d;

    // window one wins an overlap so the choice stays deterministic
    always_comb begin
        sel_d = !hit[0];
        claim_d = REQ_VALID_I && (hit != 2'b00);
        err_d = claim_d && REQ_WRITE_I && lock[sel_d];
        mvalid_d = claim_d && !err_d;
        mwrite_d = REQ_WRITE_I && mvalid_d;
        maddr_d = mvalid_d ? xaddr[sel_d] : maddr_q;
    end
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            claim_q <= 1'b0;
            mvalid_q <= 1'b0;
            mwrite_q <= 1'b0;
            sel_q <= 1'b0;
            err_q <= 1'b0;
            maddr_q <= '0;
        end else begin
            claim_q <= claim_d;
            mvalid_q <= mvalid_d;
            mwrite_q <= mwrite_d;
            sel_q <= claim_d ? sel_d : sel_q;
            err_q <= err_d;
            maddr_q <= maddr_d;
        end
    end
    assign CLAIM_O = claim_q;
    assign MEM_VALID_O = mvalid_q;
    assign MEM_WRITE_O = mwrite_q;
    assign MEM_ADDR_O = maddr_q;
    assign WIN_SEL_O = sel_q;
    assign WR_ERR_O = err_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);

    sequence s_req_miss;
        REQ_VALID_I && !cfg_q[0][EN_BIT] && !cfg_q[1][EN_BIT];
    endsequence

    a_disabled_no_claim: assert property (s_req_miss |=> !CLAIM_O)
        else $error("disabled windows claimed a request");
    a_miss_not_claimed: assert property (REQ_VALID_I && hit == 2'b00 |=> !CLAIM_O && !MEM_VALID_O)
        else $error("miss was claimed");
    a_hit_claimed: assert property (REQ_VALID_I && hit != 2'b00 |=> CLAIM_O)
        else $error("hit not claimed");
    a_locked_write_err: assert property (REQ_VALID_I && REQ_WRITE_I && hit[0] && lock[0]
        |=> WR_ERR_O && !MEM_VALID_O)
        else $error("locked write was forwarded");
    a_remap_off_pass: assert property (REQ_VALID_I && hit[0] && !cfg_q[0][REMAP_EN_BIT] && !REQ_WRITE_I
        |=> MEM_ADDR_O == $past(REQ_ADDR_I))
        else $error("address changed with remap off");
    a_remap_high_bits: assert property (REQ_VALID_I && hit[0] && cfg_q[0][REMAP_EN_BIT] && !REQ_WRITE_I
        && cfg_q[0][SIZE_LSB +: NIB_W] == 4'h0
        |=> MEM_ADDR_O[HIGH_LSB +: NIB_W] == $past(cfg_q[0][REMAP_LSB +: NIB_W]))
        else $error("high bits not replaced");
    a_wide_claim_all: assert property (REQ_VALID_I && mode_q && cfg_q[0][EN_BIT]
        && cfg_q[0][SIZE_LSB +: NIB_W] == SIZE_ALL_WIDE |=> CLAIM_O)
        else $error("64G window missed");
    a_narrow_claim_all: assert property (REQ_VALID_I && !mode_q && cfg_q[1][EN_BIT]
        && cfg_q[1][SIZE_LSB +: NIB_W] == SIZE_ALL_NARROW |=> CLAIM_O)
        else $error("4G window missed");
    a_pci_write_lands: assert property (PCI_REG_WR_I && PCI_REG_ADDR_I == WIN_TWO_OFS
        |=> cfg_q[1] == ($past(PCI_REG_WDATA_I) & CFG_USED_MASK))
        else $error("pci write lost");

endmodule

// ### rtl/window_pkg.sv
/*
 * constants for the direct processor-to-memory window decoder: register
 * offsets, field layout of a window register, size codes and address slices.
 * assumes: one 25 MHz clock domain; processor bit A[0] is address bit 35.
 */
// Summary of operation
// - two window registers at offsets 0x41C, 0x420
// - hit in enabled window is claimed, forwarded unless it is a write into a locked window
// - match field compares A[4:7] or A[0:3]
// - top nibble compared only in 36-bit mode
// - remap enable replaces the compared high bits
// - 36-bit remap also replaces A[0:3]
// - write into locked window is an error
// - disabled window claims nothing
// - 36-bit sizes 256M and 512M only, size field keeps bit 4 only
// - 32-bit sizes 256M and 512M only, size field keeps bit 4 only
// - 36-bit part without extension: size 4 cannot be stored, no claim-all
// - extended addressing: size 8 masked to 0 on write, no claim-all
// - 32-bit bus: size 4 masked to 0 on write, no claim-all
// - registers written from PCI or processor route
package window_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [15:0] WIN_ONE_OFS = 16'h041c;
    localparam logic [15:0] WIN_TWO_OFS = 16'h0420;
    localparam int REG_AW = 16;
    localparam int REG_DW = 32;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;

    // ----------------------------------------------------------------
    // window register field layout
    // ----------------------------------------------------------------
    localparam int EN_BIT = 0;
    localparam int LOCK_BIT = 1;
    localparam int REMAP_EN_BIT = 2;
    localparam int SIZE_LSB = 4;
    localparam int TOP_MATCH_LSB = 8;
    localparam int TOP_REMAP_LSB = 12;
    localparam int MATCH_LSB = 16;
    localparam int REMAP_LSB = 20;
    localparam int NIB_W = 4;
    localparam logic [31:0] CFG_USED_MASK = 32'h00ff_ff17;

    // ----------------------------------------------------------------
    // processor address slices and size codes
    // ----------------------------------------------------------------
    localparam int ADDR_W = 36;
    localparam int TOP_LSB = 32;   // A[0:3]
    localparam int HIGH_LSB = 28;  // A[4:7], or A[0:3] of a 32-bit part
    localparam logic [3:0] SIZE_ALL_NARROW = 4'h4;
    localparam logic [3:0] SIZE_ALL_WIDE = 4'h8;
    localparam int WIN_N = 2;

endpackage

// ### rtl/window_match.sv
/*
 * one direct memory window: compare, size mask and address remap.
 * assumes: purely combinational; caller registers the results.
 */
`timescale 1ns/10ps
module window_match (
    // window register and addressing mode
    input wire logic [31:0] cfg_i,
    input wire logic wide_i,
    // request address
    input wire logic [window_pkg::ADDR_W-1:0] addr_i,
    // decode results
    output logic hit_o,
    output logic lock_o,
    output logic [window_pkg::ADDR_W-1:0] addr_o
);
    import window_pkg::*;

    logic [7:0] key;
    logic [7:0] base;
    logic [7:0] remap;
    logic [7:0] mask;
    logic [7:0] new_key;
    logic [3:0] span;
    logic [3:0] size;

    // ----------------------------------------------------------------
    // compare and translate
    // ----------------------------------------------------------------
    always_comb begin
        size = cfg_i[SIZE_LSB +: NIB_W];
        if (wide_i) begin
            key = {addr_i[TOP_LSB +: NIB_W], addr_i[HIGH_LSB +: NIB_W]};
            base = {cfg_i[TOP_MATCH_LSB +: NIB_W], cfg_i[MATCH_LSB +: NIB_W]};
            remap = {cfg_i[TOP_REMAP_LSB +: NIB_W], cfg_i[REMAP_LSB +: NIB_W]};
            span = (size > SIZE_ALL_WIDE) ? SIZE_ALL_WIDE : size;
        end else begin
            // top nibble ignored; sizes beyond 4G saturate to claim-all
            key = {4'h0, addr_i[HIGH_LSB +: NIB_W]};
            base = {4'h0, cfg_i[MATCH_LSB +: NIB_W]};
            remap = {4'h0, cfg_i[REMAP_LSB +: NIB_W]};
            span = (size > SIZE_ALL_NARROW) ? SIZE_ALL_NARROW : size;
        end
        mask = 8'hff << span;
        if (!wide_i) begin
            mask = mask & 8'h0f;
        end
        hit_o = cfg_i[EN_BIT] && (((key ^ base) & mask) == 8'h00);
        lock_o = cfg_i[LOCK_BIT];
        // only the compared bits are replaced; offset bits pass through
        new_key = cfg_i[REMAP_EN_BIT] ? ((key & ~mask) | (remap & mask)) : key;
        if (wide_i) begin
            addr_o = {new_key, addr_i[HIGH_LSB-1:0]};
        end else begin
            addr_o = {addr_i[TOP_LSB +: NIB_W], new_key[3:0], addr_i[HIGH_LSB-1:0]};
        end
    end

endmodule

// ### test/cpu_bus_master.sv
/*
 * behavioural processor bus master that feeds requests to the window decoder.
 * assumes: caller enters a task just after a falling edge of clk_i; both
 * tasks return just after a later falling edge.
 */
`timescale 1ns/10ps
module cpu_bus_master (
    // clock and addressing mode
    input wire logic clk_i,
    input wire logic wide_i,
    // request lines
    output logic valid_o,
    output logic write_o,
    output logic [window_pkg::ADDR_W-1:0] addr_o
);
    import window_pkg::*;

    // quiet bus at time zero
    initial begin
        valid_o = 1'b0;
        write_o = 1'b0;
        addr_o = '0;
    end

    // one request driven across a rising edge and left on the lines until the next task; back to back allowed
    task automatic issue(input logic wr, input logic [ADDR_W-1:0] a);
        valid_o = 1'b1;
        write_o = wr;
        addr_o = wide_i ? a : {4'h0, a[31:0]};
        @(posedge clk_i);
        @(negedge clk_i);
    endtask

    // idle lines must not keep the last value, or a stale match could pass;
    // one edge passes so a following request never lands in the same step
    task automatic idle();
        valid_o = 1'b0;
        write_o = ~write_o;
        addr_o = {wide_i ? ~addr_o[35:32] : 4'h0, ~addr_o[31:0]};
        @(negedge clk_i);
    endtask
endmodule

// ### test/tb_cpu_direct_sdram_window.sv
/*
 * self-checking bench for the direct window decoder: register routes,
 * documented translation examples, claim-all size writes (stored as size 0) and random traffic.
 * assumes: the processor master model drives the request port.
 */
`timescale 1ns/10ps
module tb_cpu_direct_sdram_window;
    import window_pkg::*;
    logic CLK_I, SYS_RST_I, ADDR36_I, PCI_REG_WR_I, PCI_REG_RD_I, CPU_REG_WR_I, CPU_REG_RD_I;
    logic [15:0] PCI_REG_ADDR_I, CPU_REG_ADDR_I;
    logic [31:0] PCI_REG_WDATA_I, CPU_REG_WDATA_I, PCI_REG_RDATA_O, CPU_REG_RDATA_O;
    logic REQ_VALID_I, REQ_WRITE_I, CLAIM_O, MEM_VALID_O, MEM_WRITE_O, WIN_SEL_O, WR_ERR_O;
    logic [35:0] REQ_ADDR_I, MEM_ADDR_O, a;
    logic [31:0] cfg [2];
    logic [31:0] d;
    logic wide;
    int fails, num_checks, seed;

    direct_window u_direct_window (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .ADDR36_I(ADDR36_I),
        .PCI_REG_WR_I(PCI_REG_WR_I), .PCI_REG_RD_I(PCI_REG_RD_I), .PCI_REG_ADDR_I(PCI_REG_ADDR_I),
        .PCI_REG_WDATA_I(PCI_REG_WDATA_I), .PCI_REG_RDATA_O(PCI_REG_RDATA_O),
        .CPU_REG_WR_I(CPU_REG_WR_I), .CPU_REG_RD_I(CPU_REG_RD_I), .CPU_REG_ADDR_I(CPU_REG_ADDR_I),
        .CPU_REG_WDATA_I(CPU_REG_WDATA_I), .CPU_REG_RDATA_O(CPU_REG_RDATA_O),
        .REQ_VALID_I(REQ_VALID_I), .REQ_WRITE_I(REQ_WRITE_I), .REQ_ADDR_I(REQ_ADDR_I),
        .CLAIM_O(CLAIM_O), .MEM_VALID_O(MEM_VALID_O), .MEM_WRITE_O(MEM_WRITE_O),
        .MEM_ADDR_O(MEM_ADDR_O), .WIN_SEL_O(WIN_SEL_O), .WR_ERR_O(WR_ERR_O));
    cpu_bus_master u_cpu_bus_master (.clk_i(CLK_I), .wide_i(ADDR36_I), .valid_o(REQ_VALID_I),
        .write_o(REQ_WRITE_I), .addr_o(REQ_ADDR_I));

    // 25 MHz clock
    initial begin
        CLK_I = 1'b0;
        forever #20 CLK_I = ~CLK_I;
    end

    task automatic chk(input logic [36:0] g, input logic [36:0] e);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic give_verdict();
        if (fails == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // reference decode: {claim, forward, error, select, address}; window one wins
    function automatic logic [39:0] predict(input logic wr, input logic [35:0] x);
        logic [39:0] r;
        logic [31:0] c;
        logic [7:0] m, k, mk, rk, nk;
        logic [3:0] s8, s4;
        r = '0;
        k = wide ? x[35:28] : {4'h0, x[31:28]};
        for (int w = 1; w >= 0; w--) begin
            c = cfg[w];
            s8 = (c[7:4] > 4'd8) ? 4'd8 : c[7:4];
            s4 = (c[7:4] > 4'd4) ? 4'd4 : c[7:4];
            m = wide ? 8'hff << s8 : {4'h0, 4'hf << s4};
            mk = wide ? {c[11:8], c[19:16]} : {4'h0, c[19:16]};
            rk = wide ? {c[15:12], c[23:20]} : {4'h0, c[23:20]};
            nk = c[2] ? (k & ~m) | (rk & m) : k;
            if (c[0] && ((k ^ mk) & m) == 8'h00) begin
                r = {1'b1, ~(wr & c[1]), wr & c[1], w[0], wide ? {nk, x[27:0]} : {x[35:32], nk[3:0], x[27:0]}};
            end
        end
        return r;
    endfunction

    task automatic do_req(input logic wr, input logic [35:0] x);
        logic [39:0] e;
        e = predict(wr, wide ? x : {4'h0, x[31:0]});
        u_cpu_bus_master.issue(wr, x);
        chk(CLAIM_O, e[39]);
        chk({MEM_VALID_O, WR_ERR_O}, e[38:37]);
        if (e[39]) chk(WIN_SEL_O, e[36]);
        if (e[38]) chk({MEM_WRITE_O, MEM_ADDR_O}, {wr, e[35:0]});
    endtask

    // route 0 is the PCI window, route 1 the processor window
    task automatic reg_wr(input logic r, input logic [15:0] ad, input logic [31:0] dt);
        {PCI_REG_ADDR_I, CPU_REG_ADDR_I, PCI_REG_WDATA_I, CPU_REG_WDATA_I} = {ad, ad, dt, dt};
        {PCI_REG_WR_I, CPU_REG_WR_I} = {~r, r};
        if (ad == WIN_ONE_OFS) cfg[0] = dt & CFG_USED_MASK;
        if (ad == WIN_TWO_OFS) cfg[1] = dt & CFG_USED_MASK;
        @(posedge CLK_I);
        @(negedge CLK_I);
        {PCI_REG_WR_I, CPU_REG_WR_I} = 2'b00;
    endtask

    task automatic reg_rd(input logic r, input logic [15:0] ad, input logic [31:0] e);
        {PCI_REG_ADDR_I, CPU_REG_ADDR_I} = {ad, ad};
        {PCI_REG_RD_I, CPU_REG_RD_I} = {~r, r};
        @(posedge CLK_I);
        @(negedge CLK_I);
        {PCI_REG_RD_I, CPU_REG_RD_I} = 2'b00;
        chk(r ? CPU_REG_RDATA_O : PCI_REG_RDATA_O, e);
    endtask

    // mode strap passes two flops, so let it settle before traffic
    task automatic set_mode(input logic w);
        u_cpu_bus_master.idle();
        ADDR36_I = w;
        wide = w;
        repeat (3) @(negedge CLK_I);
    endtask

    // watchdog: the whole run needs under a thousand cycles, the limit is 30000
    initial begin
        #1_200_000;
        fails++;
        give_verdict();
    end

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        {fails, num_checks, seed} = {32'h0, 32'h0, 32'hd573_f67f};
        {SYS_RST_I, ADDR36_I, wide, PCI_REG_WR_I, PCI_REG_RD_I, CPU_REG_WR_I, CPU_REG_RD_I} = 7'b100_0000;
        {PCI_REG_ADDR_I, CPU_REG_ADDR_I, PCI_REG_WDATA_I, CPU_REG_WDATA_I} = '0;
        cfg[0] = '0;
        cfg[1] = '0;
        repeat (3) @(posedge CLK_I);
        @(negedge CLK_I);
        SYS_RST_I = 1'b0;
        reg_rd(1'b0, WIN_ONE_OFS, 32'h0000_0000);
        reg_rd(1'b1, WIN_TWO_OFS, 32'h0000_0000);
        reg_wr(1'b0, 16'h0424, 32'hffff_ffff);
        reg_rd(1'b1, 16'h0424, 32'h0000_0000);
        reg_wr(1'b0, WIN_ONE_OFS, 32'hffff_fffe);
        reg_rd(1'b1, WIN_ONE_OFS, 32'hffff_fffe & CFG_USED_MASK);
        do_req(1'b0, 36'h0_0000_0000);
        // translation example on the wide bus
        set_mode(1'b1);
        reg_wr(1'b1, WIN_TWO_OFS, 32'h0001_a105);
        do_req(1'b0, 36'h1_1f00_0004);
        chk(MEM_ADDR_O, 36'ha_0f00_0004);
        do_req(1'b1, 36'h1_2000_0000);
        reg_wr(1'b0, WIN_ONE_OFS, 32'h0000_0081);
        do_req(1'b0, 36'h1_1f00_0004);
        do_req(1'b1, 36'hf_ffff_fff0);
        // translation example on the narrow bus
        set_mode(1'b0);
        reg_wr(1'b1, WIN_ONE_OFS, 32'h0000_0000);
        reg_wr(1'b0, WIN_TWO_OFS, 32'h0031_0005);
        do_req(1'b0, 36'h0_1e00_0008);
        chk(MEM_ADDR_O, 36'h0_3e00_0008);
        reg_wr(1'b1, WIN_ONE_OFS, 32'h0000_0043);
        do_req(1'b1, 36'h0_9abc_def0);
        // random windows and traffic, hits steered half the time
        for (int i = 0; i < 400; i++) begin
            if (i % 25 == 0) begin
                set_mode(1'($random(seed) & 1));
                for (int w = 0; w < 2; w++) begin
                    d = $random(seed) & 32'hffff_ff0f;
                    d[7:4] = 4'(($random(seed) & 32'h7fff_ffff) % 9);
                    d[0] = |d[9:8];
                    reg_wr(d[31], w ? WIN_TWO_OFS : WIN_ONE_OFS, d);
                end
            end
            a = 36'({$random(seed), $random(seed)});
            if (a[33]) a[35:28] = wide ? {cfg[a[34]][11:8], cfg[a[34]][19:16]} : {4'h0, cfg[a[34]][19:16]};
            if (!wide && a[33]) a[31:28] = cfg[a[34]][19:16];
            do_req(a[32], a);
            // a quiet cycle must leave claim, forward and error low
            if (a[0] & a[1]) begin
                u_cpu_bus_master.idle();
                chk({CLAIM_O, MEM_VALID_O, WR_ERR_O}, 3'b000);
            end
        end
        u_cpu_bus_master.idle();
        give_verdict();
    end
endmodule
